/* File: efl_cfg.svh */
// register map, field positions, codes and reset values of the error recorder
// assumes word-indexed register port with 16-bit data
`ifndef EFL_CFG_SVH
`define EFL_CFG_SVH

// register indices
`define EFL_A_CODE 8'h00
`define EFL_A_FLAGS 8'h01
`define EFL_A_STATUS 8'h02
`define EFL_A_BUSU 8'h03
`define EFL_A_SIO0 8'h04
`define EFL_A_SIO5 8'h09
`define EFL_A_PTR 8'h0A
`define EFL_A_SETUP 8'h0B
`define EFL_A_BUSRST 8'h0C
`define EFL_A_SIORST 8'h0D
`define EFL_A_USER 8'h0E
`define EFL_A_LOG 8'h10
`define EFL_LOG_WORDS 8'd100

// log geometry
`define EFL_LOG_RECS 20
`define EFL_LOG_FULL 5'd20
`define EFL_REC_WORDS 7'd5

// error flag word, status word and setup word bit positions
`define EFL_BIT_USER 15
`define EFL_BIT_BUS 7
`define EFL_BIT_SIO 6
`define EFL_BIT_BATT 4
`define EFL_BIT_OTHER 0
`define EFL_BIT_OPT 13
`define EFL_BIT_BATT_EN 0

// error codes
`define EFL_CODE_NONE 16'h0000
`define EFL_CODE_BUS_BASE 16'h0200
`define EFL_CODE_SIO_BASE 16'h0300
`define EFL_CODE_SIO_UNK 16'h03FF
`define EFL_CODE_BATT 16'h00F7

// special unit numbering
`define EFL_SIO_MAX 7'h5F
`define EFL_SIO_UNK_ID 7'h7F

// pin synchroniser reset: {fitted, low, opt slot 2, opt slot 1}
`define EFL_PIN_RST 4'h8

`endif

/* File: efl_pkg.sv */
// types shared by the error recorder
// assumes nothing beyond a SystemVerilog compiler
package efl_pkg;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_USER = 3'b001,
    SRC_BUS = 3'b010,
    SRC_SIO = 3'b011,
    SRC_OPT = 3'b100,
    SRC_BATT = 3'b101
  } efl_src_e;

  typedef logic [15:0] efl_word_t;
  typedef logic [79:0] efl_rec_t;

endpackage

/* File: efl_recorder.sv */
// non-fatal error flags, unit number flags, error code and 20-record log
// assumes unit fail reports and the time word come from logic on CLOCK;
// option board and battery pins are asynchronous
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "efl_cfg.svh"
module efl_recorder
  import efl_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // unit exchange reports
  input wire logic BUS_FAIL,
  input wire logic [3:0] BUS_UNIT,
  input wire logic SIO_FAIL,
  input wire logic SIO_UNIT_KNOWN,
  input wire logic [6:0] SIO_UNIT,
  // asynchronous pins
  input wire logic [1:0] OPT_PRESENT,
  input wire logic BATT_LOW,
  input wire logic BATT_FITTED,
  // time of day
  input wire logic [47:0] TIME_NOW,
  // display and unit restarts
  output logic [15:0] DISP_CODE,
  output logic [15:0] BUS_RESTART,
  output logic SIO_RESTART,
  output logic [6:0] SIO_RESTART_UNIT
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic efl_word_t rec_word(input efl_rec_t r, input logic [6:0] w);
    efl_word_t v;
    v = 16'h0000;
    case (w)
      7'h00: v = r[79:64];
      7'h01: v = r[63:48];
      7'h02: v = r[15:0];
      7'h03: v = r[31:16];
      7'h04: v = r[47:32];
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic [95:0] sio_onehot(input logic [6:0] n);
    return {95'h0, 1'b1} << n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, change taken once stages two and three agree

  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_s3_reg;
  logic [3:0] pin_f_reg;
  wire [3:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  wire [3:0] pin_f_next = (pin_s3_reg & pin_agree) | (pin_f_reg & ~pin_agree);

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1_reg <= `EFL_PIN_RST;
      pin_s2_reg <= `EFL_PIN_RST;
      pin_s3_reg <= `EFL_PIN_RST;
      pin_f_reg <= `EFL_PIN_RST;
    end
    else
    begin
      pin_s1_reg <= {BATT_FITTED, BATT_LOW, OPT_PRESENT};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_f_reg <= pin_f_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_setup = WR && (ADDR == `EFL_A_SETUP);
  wire wr_bus_rst = WR && (ADDR == `EFL_A_BUSRST);
  wire wr_sio_rst = WR && (ADDR == `EFL_A_SIORST);
  wire wr_user = WR && (ADDR == `EFL_A_USER);

  ////////////////////////////////////////////////////////////////////////////
  // error sources and priority

  logic batt_en_reg;
  logic batt_flag_reg;
  logic opt_flag_reg;
  logic user_flag_reg;
  logic sio_unk_reg;
  logic [15:0] bus_unit_reg;
  logic [95:0] sio_unit_reg;
  logic [15:0] code_reg;
  logic [4:0] ptr_reg;
  efl_rec_t log_reg [0:`EFL_LOG_RECS-1];

  // removal counts only once the filtered level falls, i.e. with power on
  wire [1:0] opt_gone = pin_f_reg[1:0] & ~pin_f_next[1:0];
  wire opt_ev = |opt_gone;
  // a stuck level logs once; the sticky flag masks it afterwards
  wire batt_level = batt_en_reg & (pin_f_reg[2] | ~pin_f_reg[3]);
  wire batt_ev = batt_level & ~batt_flag_reg;
  wire sio_known = SIO_UNIT_KNOWN && (SIO_UNIT <= `EFL_SIO_MAX);

  // one record per cycle; a lesser error in the same cycle keeps its flags only
  wire efl_src_e src = efl_src_e'(wr_user ? SRC_USER :
                                  BUS_FAIL ? SRC_BUS :
                                  SIO_FAIL ? SRC_SIO :
                                  opt_ev ? SRC_OPT :
                                  batt_ev ? SRC_BATT : SRC_NONE);
  wire log_ev = (src != SRC_NONE);

  wire efl_word_t sio_code = sio_known ? (`EFL_CODE_SIO_BASE | {9'h000, SIO_UNIT})
                                       : `EFL_CODE_SIO_UNK;
  wire efl_word_t rec_code = (src == SRC_USER) ? WDATA :
                             (src == SRC_BUS) ? (`EFL_CODE_BUS_BASE | {12'h000, BUS_UNIT}) :
                             (src == SRC_SIO) ? sio_code :
                             (src == SRC_BATT) ? `EFL_CODE_BATT : `EFL_CODE_NONE;
  wire efl_word_t rec_info = (src == SRC_BUS) ? {12'h000, BUS_UNIT} :
                             (src == SRC_SIO) ? {9'h000, SIO_UNIT} :
                             (src == SRC_OPT) ? {14'h0000, opt_gone} :
                             (src == SRC_BATT) ? {14'h0000, ~pin_f_reg[3], pin_f_reg[2]} :
                             16'h0000;
  wire efl_rec_t new_rec = {rec_code, rec_info, TIME_NOW};

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, set wins over clear

  wire [15:0] bus_set = BUS_FAIL ? (16'h0001 << BUS_UNIT) : 16'h0000;
  wire [15:0] bus_clr = wr_bus_rst ? WDATA : 16'h0000;
  wire [15:0] bus_unit_next = (bus_unit_reg & ~bus_clr) | bus_set;
  wire [95:0] sio_set = (SIO_FAIL && sio_known) ? sio_onehot(SIO_UNIT) : 96'h0;
  wire [95:0] sio_clr = (wr_sio_rst && (WDATA[6:0] <= `EFL_SIO_MAX)) ?
                        sio_onehot(WDATA[6:0]) : 96'h0;
  wire [95:0] sio_unit_next = (sio_unit_reg & ~sio_clr) | sio_set;
  wire unk_clr = wr_sio_rst && (WDATA[6:0] == `EFL_SIO_UNK_ID);
  wire sio_unk_next = (sio_unk_reg & ~unk_clr) | (SIO_FAIL && !sio_known);

  wire efl_word_t err_word = ({15'h0000, user_flag_reg} << `EFL_BIT_USER) |
                             ({15'h0000, |bus_unit_reg} << `EFL_BIT_BUS) |
                             ({15'h0000, (|sio_unit_reg) | sio_unk_reg} << `EFL_BIT_SIO) |
                             ({15'h0000, batt_flag_reg} << `EFL_BIT_BATT) |
                             ({15'h0000, opt_flag_reg} << `EFL_BIT_OTHER);
  wire efl_word_t status_word = {15'h0000, opt_flag_reg} << `EFL_BIT_OPT;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bus_unit_reg <= 16'h0000;
      sio_unit_reg <= 96'h0;
      sio_unk_reg <= 1'b0;
      opt_flag_reg <= 1'b0;
      batt_flag_reg <= 1'b0;
      user_flag_reg <= 1'b0;
      batt_en_reg <= 1'b0;
    end
    else
    begin
      bus_unit_reg <= bus_unit_next;
      sio_unit_reg <= sio_unit_next;
      sio_unk_reg <= sio_unk_next;
      opt_flag_reg <= opt_flag_reg | opt_ev;
      batt_flag_reg <= batt_flag_reg | batt_ev;
      user_flag_reg <= user_flag_reg | wr_user;
      if (wr_setup)
        batt_en_reg <= WDATA[`EFL_BIT_BATT_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error code word, display and restart pulses

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      code_reg <= `EFL_CODE_NONE;
      DISP_CODE <= `EFL_CODE_NONE;
      BUS_RESTART <= 16'h0000;
      SIO_RESTART <= 1'b0;
      SIO_RESTART_UNIT <= 7'h00;
    end
    else
    begin
      // option board removal carries no code of its own
      if (log_ev && (src != SRC_OPT))
        code_reg <= rec_code;
      if (log_ev)
        DISP_CODE <= rec_code;
      BUS_RESTART <= bus_clr;
      SIO_RESTART <= wr_sio_rst;
      if (wr_sio_rst)
        SIO_RESTART_UNIT <= WDATA[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // log area, shift and append in the same edge

  wire log_full = (ptr_reg == `EFL_LOG_FULL);
  wire [4:0] ptr_next = log_full ? ptr_reg : ptr_reg + 5'd1;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ptr_reg <= 5'd0;
      for (int i = 0; i < `EFL_LOG_RECS; i++)
        log_reg[i] <= 80'h0;
    end
    else if (log_ev)
    begin
      ptr_reg <= ptr_next;
      if (log_full)
      begin
        for (int i = 0; i < `EFL_LOG_RECS - 1; i++)
          log_reg[i] <= log_reg[i+1];
        log_reg[`EFL_LOG_RECS-1] <= new_rec;
      end
      else
        log_reg[ptr_reg] <= new_rec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, unmapped indices read zero

  wire [7:0] log_idx = ADDR - `EFL_A_LOG;
  wire in_log = (ADDR >= `EFL_A_LOG) && (log_idx < `EFL_LOG_WORDS);
  wire [6:0] log_rec = log_idx[6:0] / `EFL_REC_WORDS;
  wire [6:0] log_wrd = log_idx[6:0] % `EFL_REC_WORDS;
  wire efl_word_t log_val = in_log ? rec_word(log_reg[log_rec[4:0]], log_wrd) : 16'h0000;
  wire [7:0] sio_idx = ADDR - `EFL_A_SIO0;
  wire [95:0] sio_shift = sio_unit_reg >> {sio_idx[2:0], 4'h0};
  wire in_sio = (ADDR >= `EFL_A_SIO0) && (ADDR <= `EFL_A_SIO5);
  wire efl_word_t rd_val = in_log ? log_val :
                           in_sio ? sio_shift[15:0] :
                           (ADDR == `EFL_A_CODE) ? code_reg :
                           (ADDR == `EFL_A_FLAGS) ? err_word :
                           (ADDR == `EFL_A_STATUS) ? status_word :
                           (ADDR == `EFL_A_BUSU) ? bus_unit_reg :
                           (ADDR == `EFL_A_PTR) ? {11'h000, ptr_reg} :
                           (ADDR == `EFL_A_SETUP) ? {15'h0000, batt_en_reg} :
                           16'h0000;

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      RDATA <= 16'h0000;
    else
      RDATA <= RD ? rd_val : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking efl_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence bus_only_s;
    BUS_FAIL && !wr_user;
  endsequence

  sequence full_log_s;
    log_ev && log_full;
  endsequence

  bus_code_a: assert property (
    bus_only_s |=> code_reg == (`EFL_CODE_BUS_BASE | {12'h000, $past(BUS_UNIT)}))
    else $error("bus unit code wrong");

  bus_flag_a: assert property (
    BUS_FAIL |=> err_word[`EFL_BIT_BUS] && bus_unit_reg[$past(BUS_UNIT)])
    else $error("bus unit flag not set");

  sio_unk_a: assert property (
    SIO_FAIL && !sio_known && src == SRC_SIO |=> code_reg == `EFL_CODE_SIO_UNK && sio_unk_reg)
    else $error("unknown special unit not coded");

  sio_flag_a: assert property (
    SIO_FAIL && sio_known |=> sio_unit_reg[$past(SIO_UNIT)] && err_word[`EFL_BIT_SIO])
    else $error("special unit flag not set");

  bus_restart_a: assert property (
    wr_bus_rst && !BUS_FAIL |=> BUS_RESTART == $past(WDATA) &&
      (bus_unit_reg & $past(WDATA)) == 16'h0000 ##1 BUS_RESTART == 16'h0000 || $past(wr_bus_rst))
    else $error("restart pulse or clear wrong");

  opt_flag_a: assert property (
    opt_ev |=> status_word[`EFL_BIT_OPT] && err_word[`EFL_BIT_OTHER])
    else $error("option board flags not set");

  batt_off_a: assert property (
    !batt_en_reg |=> !$rose(batt_flag_reg))
    else $error("battery error while detection off");

  batt_code_a: assert property (
    batt_ev && src == SRC_BATT |=> code_reg == `EFL_CODE_BATT && err_word[`EFL_BIT_BATT])
    else $error("battery code wrong");

  log_write_a: assert property (
    log_ev && !log_full |=> log_reg[$past(ptr_reg)][79:64] == DISP_CODE)
    else $error("log record code mismatch");

  ptr_cap_a: assert property (
    ptr_reg <= `EFL_LOG_FULL)
    else $error("pointer above log size");

  log_shift_a: assert property (
    full_log_s |=> log_reg[0] == $past(log_reg[1]) &&
      log_reg[`EFL_LOG_RECS-1][79:64] == DISP_CODE && log_full)
    else $error("log shift wrong");

  ptr_step_a: assert property (
    log_ev && !log_full |=> ptr_reg == $past(ptr_reg) + 5'd1)
    else $error("pointer did not step");

  prio_code_a: assert property (
    bus_only_s ##0 SIO_FAIL |=> code_reg[15:8] == `EFL_CODE_BUS_BASE >> 8)
    else $error("lesser error code won");

  bus_sticky_a: assert property (
    !wr_bus_rst |=> (bus_unit_reg & $past(bus_unit_reg)) == $past(bus_unit_reg))
    else $error("unit flag fell without restart");

endmodule

/* File: efl_unit_model.sv */
// model of the expansion units facing the error recorder
// assumes the bench asks for failure reports through report()
`timescale 1ns/1ns
module efl_unit_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // restart pulses from the recorder
  input wire logic [15:0] bus_restart,
  input wire logic sio_restart,
  input wire logic [6:0] sio_restart_unit,
  // failure reports to the recorder
  output logic bus_fail,
  output logic [3:0] bus_unit,
  output logic sio_fail,
  output logic sio_unit_known,
  output logic [6:0] sio_unit
);
  logic [15:0] bus_halted;
  logic [95:0] sio_halted;
  wire [15:0] bus_hit = bus_fail ? (16'h0001 << bus_unit) : 16'h0000;
  wire [95:0] sio_hit = (sio_fail && sio_unit_known) ? ({95'h0, 1'b1} << sio_unit) : 96'h0;
  wire [95:0] sio_go = sio_restart ? ({95'h0, 1'b1} << sio_restart_unit) : 96'h0;

  initial
  begin
    bus_fail = 1'b0;
    bus_unit = 4'h0;
    sio_fail = 1'b0;
    sio_unit_known = 1'b0;
    sio_unit = 7'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a failed unit stays halted until its restart bit arrives
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      bus_halted <= 16'h0000;
      sio_halted <= 96'h0;
    end
    else
    begin
      bus_halted <= (bus_halted & ~bus_restart) | bus_hit;
      sio_halted <= (sio_halted & ~sio_go) | sio_hit;
    end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle report; unit lines show the inverse once released
  task automatic report(input logic b, input logic s, input logic [3:0] bu, input logic kn,
                        input logic [6:0] su);
    @(posedge clock);
    bus_fail <= b;
    bus_unit <= bu;
    sio_fail <= s;
    sio_unit_known <= kn;
    sio_unit <= su;
    @(posedge clock);
    bus_fail <= 1'b0;
    sio_fail <= 1'b0;
    bus_unit <= ~bu;
    sio_unit_known <= ~kn;
    sio_unit <= ~su;
  endtask
endmodule

/* File: efl_recorder_tb.sv */
// self-checking bench for the error recorder
// assumes the unit model drives the failure reports
`timescale 1ns/1ns
`include "efl_cfg.svh"
module efl_recorder_tb
  import efl_pkg::*;
;
  logic clock, rst_n, wr, rd, bus_fail, sio_fail, sio_known, sio_restart, batt_low, batt_fitted;
  logic [7:0] addr;
  logic [3:0] bus_unit;
  logic [6:0] sio_unit, sio_rst_unit;
  logic [1:0] opt_present;
  logic [47:0] time_now;
  efl_word_t wdata, rdata, disp_code, bus_restart;
  efl_word_t exp_log[$];
  int mismatches, compares, cycles, exp_ptr;

  efl_recorder efl_recorder_i (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .BUS_FAIL(bus_fail), .BUS_UNIT(bus_unit),
    .SIO_FAIL(sio_fail), .SIO_UNIT_KNOWN(sio_known), .SIO_UNIT(sio_unit),
    .OPT_PRESENT(opt_present), .BATT_LOW(batt_low), .BATT_FITTED(batt_fitted),
    .TIME_NOW(time_now), .DISP_CODE(disp_code), .BUS_RESTART(bus_restart),
    .SIO_RESTART(sio_restart), .SIO_RESTART_UNIT(sio_rst_unit));

  efl_unit_model efl_unit_model_i (.clock(clock), .rst_n(rst_n), .bus_restart(bus_restart),
    .sio_restart(sio_restart), .sio_restart_unit(sio_rst_unit), .bus_fail(bus_fail),
    .bus_unit(bus_unit), .sio_fail(sio_fail), .sio_unit_known(sio_known), .sio_unit(sio_unit));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic complete_run();
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // tests should need well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input efl_word_t seen, input efl_word_t exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input efl_word_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input efl_word_t exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk($sformatf("reg %h", a), rdata, exp);
  endtask

  // expected log: oldest dropped once twenty are held
  task automatic logged(input efl_word_t code);
    exp_log.push_back(code);
    if (exp_log.size() > 20)
      void'(exp_log.pop_front());
    if (exp_ptr < 20)
      exp_ptr++;
  endtask

  task automatic pulse_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    opt_present = 2'b11;
    batt_low = 1'b0;
    batt_fitted = 1'b1;
    time_now = 48'h1234_5678_9ABC;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    rd_chk(`EFL_A_FLAGS, 16'h0000);
    rd_chk(`EFL_A_PTR, 16'h0000);
    rd_chk(`EFL_A_SETUP, 16'h0000);
    rd_chk(8'h7F, 16'h0000);
    // bus unit failure, record and display
    efl_unit_model_i.report(1'b1, 1'b0, 4'h3, 1'b1, 7'h00);
    logged(16'h0203);
    // display launches on the report's last edge, look once settled
    @(negedge clock);
    chk("disp", disp_code, 16'h0203);
    chk("unit halted", efl_unit_model_i.bus_halted, 16'h0008);
    rd_chk(`EFL_A_CODE, 16'h0203);
    rd_chk(`EFL_A_FLAGS, 16'h0080);
    rd_chk(`EFL_A_BUSU, 16'h0008);
    rd_chk(`EFL_A_PTR, 16'h0001);
    rd_chk(`EFL_A_LOG, 16'h0203);
    rd_chk(8'h11, 16'h0003);
    rd_chk(8'h12, 16'h9ABC);
    rd_chk(8'h13, 16'h5678);
    rd_chk(8'h14, 16'h1234);
    wr_reg(`EFL_A_BUSRST, 16'h0008);
    @(negedge clock);
    chk("bus restart", bus_restart, 16'h0008);
    @(negedge clock);
    chk("bus restart end", bus_restart, 16'h0000);
    chk("unit restarted", efl_unit_model_i.bus_halted, 16'h0000);
    rd_chk(`EFL_A_BUSU, 16'h0000);
    rd_chk(`EFL_A_FLAGS, 16'h0000);
    // special unit failures, known top unit and unknown
    efl_unit_model_i.report(1'b0, 1'b1, 4'h0, 1'b1, 7'h5F);
    logged(16'h035F);
    @(negedge clock);
    chk("sio halted", efl_unit_model_i.sio_halted[95:80], 16'h8000);
    rd_chk(`EFL_A_CODE, 16'h035F);
    rd_chk(`EFL_A_FLAGS, 16'h0040);
    rd_chk(`EFL_A_SIO5, 16'h8000);
    efl_unit_model_i.report(1'b0, 1'b1, 4'h0, 1'b0, 7'h11);
    logged(16'h03FF);
    rd_chk(`EFL_A_CODE, 16'h03FF);
    wr_reg(`EFL_A_SIORST, 16'h005F);
    @(negedge clock);
    chk("sio restart", {15'h0000, sio_restart}, 16'h0001);
    chk("sio unit", {9'h000, sio_rst_unit}, 16'h005F);
    rd_chk(`EFL_A_SIO5, 16'h0000);
    chk("sio restarted", efl_unit_model_i.sio_halted[95:80], 16'h0000);
    wr_reg(`EFL_A_SIORST, 16'h007F);
    rd_chk(`EFL_A_FLAGS, 16'h0000);
    // battery low ignored until detection is enabled
    @(posedge clock);
    batt_low <= 1'b1;
    repeat (8) @(posedge clock);
    rd_chk(`EFL_A_FLAGS, 16'h0000);
    wr_reg(`EFL_A_SETUP, 16'h0001);
    repeat (6) @(posedge clock);
    logged(16'h00F7);
    rd_chk(`EFL_A_CODE, 16'h00F7);
    rd_chk(`EFL_A_FLAGS, 16'h0010);
    rd_chk(`EFL_A_SETUP, 16'h0001);
    // option board pulled from slot 1, code word untouched
    @(posedge clock);
    opt_present <= 2'b10;
    repeat (8) @(posedge clock);
    logged(16'h0000);
    rd_chk(`EFL_A_STATUS, 16'h2000);
    rd_chk(`EFL_A_FLAGS, 16'h0011);
    rd_chk(`EFL_A_CODE, 16'h00F7);
    // bus and special failure in the same cycle
    efl_unit_model_i.report(1'b1, 1'b1, 4'h1, 1'b1, 7'h02);
    logged(16'h0201);
    rd_chk(`EFL_A_CODE, 16'h0201);
    rd_chk(`EFL_A_FLAGS, 16'h00D1);
    rd_chk(`EFL_A_BUSU, 16'h0002);
    rd_chk(`EFL_A_SIO0, 16'h0004);
    rd_chk(`EFL_A_PTR, 16'(exp_ptr));
    // user errors past a full log
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(`EFL_A_USER, 16'h4101 + 16'(i));
      logged(16'h4101 + 16'(i));
    end
    rd_chk(`EFL_A_PTR, 16'h0014);
    rd_chk(`EFL_A_CODE, 16'h4110);
    rd_chk(`EFL_A_FLAGS, 16'h80D1);
    for (int i = 0; i < 20; i++)
      rd_chk(8'(`EFL_A_LOG + 5 * i), exp_log[i]);
    // reset in mid-run clears everything sticky
    pulse_reset();
    rd_chk(`EFL_A_FLAGS, 16'h0000);
    rd_chk(`EFL_A_STATUS, 16'h0000);
    rd_chk(`EFL_A_PTR, 16'h0000);
    // missing battery counts too, but only once detection is on
    @(posedge clock);
    batt_low <= 1'b0;
    batt_fitted <= 1'b0;
    repeat (8) @(posedge clock);
    rd_chk(`EFL_A_FLAGS, 16'h0000);
    wr_reg(`EFL_A_SETUP, 16'h0001);
    repeat (2) @(posedge clock);
    rd_chk(`EFL_A_CODE, 16'h00F7);
    rd_chk(`EFL_A_FLAGS, 16'h0010);
    rd_chk(8'h11, 16'h0002);
    rd_chk(`EFL_A_PTR, 16'h0001);
    complete_run();
  end
endmodule
